/* hbc_pkg.sv */
/*
  constants shared by the h-bridge configuration and status logic: frame
  layout, command codes, field positions and reset values.
  assumes nothing of its surroundings.
*/
`default_nettype none
package hbc_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CMD_BITS   = 8;
  localparam int CNT_W      = 5;
  // serial commands, first byte of a frame
  localparam logic [7:0] CMD_RD_DIAG = 8'h00;
  localparam logic [7:0] CMD_RD_ID   = 8'h01;
  localparam logic [7:0] CMD_RD_REV  = 8'h02;
  localparam logic [7:0] CMD_RD_CFG  = 8'h03;
  localparam logic [7:0] CMD_RD_STC  = 8'h04;
  localparam logic [7:0] CMD_WR_CFG  = 8'h83;
  localparam logic [7:0] CMD_WR_STC  = 8'h84;
  // configuration fields
  localparam int CFG_MODE  = 7;
  localparam int CFG_SRC   = 6;
  localparam int CFG_SA    = 5;
  localparam int CFG_SB    = 4;
  localparam int CFG_IL_HI = 3;
  localparam int CFG_IL_LO = 2;
  localparam int CFG_RST_N = 1;
  localparam int CFG_EDGE  = 0;
  localparam logic [7:0] CFG_RESET = 8'hfa;
  localparam logic [7:0] CFG_FORCE = 8'h72;
  localparam logic [1:0] ILIM_LVL4 = 2'h3;
  localparam logic [1:0] ILIM_LVL3 = 2'h2;
  // supply test and status fields; bits 7:5 are stored
  localparam int STC_CLR_B = 4;
  localparam int STC_CLR_A = 3;
  localparam logic [2:0] STC_RESET = 3'h6;
  // fault report register
  localparam int DIAG_W = 7;
  localparam logic [6:0] DIAG_RESET = 7'h7f;
  localparam logic [6:0] DIAG_RD_SET = 7'h70;
  localparam logic [6:0] DIAG_A_SET  = 7'h03;
  localparam logic [6:0] DIAG_B_SET  = 7'h0c;
  // synchroniser lanes
  localparam int SY_N    = 10;
  localparam int SY_SCK  = 0;
  localparam int SY_CS_N = 1;
  localparam int SY_MOSI = 2;
  localparam int SY_PA   = 3;
  localparam int SY_PB   = 4;
  localparam int SY_EN   = 5;
  localparam int SY_DIS  = 6;
  localparam int SY_FLAG = 7;
  localparam int SY_UV   = 8;
  localparam int SY_OV   = 9;
  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_CMD  = 2'b01,
    FR_DATA = 2'b10,
    FR_DONE = 2'b11
  } hbc_frame_t;
endpackage
`default_nettype wire

/* hbc_regs.sv */
/*
  configuration, supply test/status and fault report registers of a serially
  programmed h-bridge driver, with the serial slave that reaches them.
  assumes: all pins are asynchronous to clk and slow against it (serial clock
  period at least 8 clk); srst is the logic-supply power-up reset.
*/
`default_nettype none
// How it works
// - cfg bit 7: bridge or single stages
// - cfg bit 6 picks pin or serial drive
// - bits 5/4 drive outputs when serial
// - bits 3:2 pick current level 1-4
// - writing 0 to bit 1 resets logic
// - power-up loads fa, d8, diagnosis ones
// - commanded reset equals power-up contents
// - enable pin edges set diagnosis ones
// - held off forces select, drives, reset
// - diagnosis read re-arms bits 6:4 only
// - clear-a zero sets diagnosis 1:0
// - clear-b zero sets diagnosis 3:2
// - clear bits always read as one
// - flag-only mode resets cfg, supply test
// - identifier and revision never reset
// - unlisted resets leave registers alone
// - supply test bit 7 selects test mode
// - bit 6 picks which threshold shifts
// - bit 5 latches overvoltage indication
// - status bit 2 shows enable pin
// - status bit 1 low in undervoltage
// - status bit 0 low in overvoltage
// - diagnosis flags are active low
module hbc_regs #(
  parameter logic [7:0] PART_ID  = 8'h5a, // arbitrary value
  parameter logic [7:0] REVISION = 8'h11  // arbitrary value
) (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic                       sclk,
  input  wire logic                       cs_n,
  input  wire logic                       mosi,
  output logic                            miso,
  output logic                            miso_oe,
  input  wire logic                       parallel_drive_a,
  input  wire logic                       parallel_drive_b,
  input  wire logic                       bridge_enable_pin_n,
  input  wire logic                       bridge_disable_pin,
  input  wire logic                       flag_only_mode,
  input  wire logic                       supply_under,
  input  wire logic                       supply_over,
  input  wire logic [hbc_pkg::DIAG_W-1:0] fault_event_n,
  output logic                            bridge_output_a,
  output logic                            bridge_output_b,
  output logic                            stage_enable,
  output logic                            hbridge_mode,
  output logic [1:0]                      ilim_level,
  output logic                            edge_rate_select,
  output logic                            threshold_test_off,
  output logic                            threshold_shift_dir,
  output logic                            commanded_logic_clear
);
  import hbc_pkg::*;

  logic [SY_N-1:0]       meta_q, sync_q, prev_q;
  hbc_frame_t            fr_q, fr_d;
  logic [CNT_W-1:0]      cnt_q;
  logic [FRAME_BITS-1:0] rx_q;
  logic [CMD_BITS-1:0]   cmd_q;
  logic [7:0]            tx_q, cfg_q, cfg_d;
  logic [2:0]            stc_q, stc_d;
  logic [DIAG_W-1:0]     diag_q, diag_d;
  logic                  ov_hold_q, miso_q, oe_q, out_a_q, out_b_q, en_q, mode_q;
  logic [1:0]            ilim_q;
  logic                  edge_q, tst_q, dir_q, clr_q;

  // every pin but srst and fault_event_n passes two flops; edges are found on the second stage only
  always_ff @(posedge clk) begin
    meta_q <= {supply_over, supply_under, flag_only_mode, bridge_disable_pin,
               bridge_enable_pin_n, parallel_drive_b, parallel_drive_a, mosi, cs_n, sclk};
    sync_q <= meta_q;
    prev_q <= sync_q;
  end

  wire sck_rise = sync_q[SY_SCK] & ~prev_q[SY_SCK];
  wire sck_fall = ~sync_q[SY_SCK] & prev_q[SY_SCK];
  wire cs_act   = ~sync_q[SY_CS_N];
  wire cs_start = cs_act & prev_q[SY_CS_N];
  wire en_edge  = (sync_q[SY_EN] ^ prev_q[SY_EN]) | (sync_q[SY_DIS] ^ prev_q[SY_DIS]);
  // stage is held off by a low enable pin or a high disable pin
  wire held_off = ~sync_q[SY_EN] | sync_q[SY_DIS];
  wire sf_mode  = sync_q[SY_FLAG];

  wire [7:0] rx_byte  = {rx_q[6:0], sync_q[SY_MOSI]};
  wire       last_bit = sck_rise & (cnt_q == CNT_W'(FRAME_BITS - 1));
  wire       cmd_bit  = sck_rise & (cnt_q == CNT_W'(CMD_BITS - 1));
  wire       done     = (fr_q == FR_DATA) & last_bit;
  wire       wr_cfg   = done & (cmd_q == CMD_WR_CFG);
  wire       wr_stc   = done & (cmd_q == CMD_WR_STC);
  wire       rd_diag  = done & (cmd_q == CMD_RD_DIAG);
  wire       cmd_clr  = wr_cfg & ~rx_byte[CFG_RST_N];

  // live status: enable pin, undervoltage, overvoltage (optionally latched)
  wire ov_seen = sync_q[SY_OV] | (stc_q[0] & ov_hold_q);
  wire [7:0] stc_rd  = {stc_q, 2'b11, sync_q[SY_EN], ~sync_q[SY_UV], ~ov_seen};
  wire [7:0] diag_rd = {~held_off, diag_q};

  function automatic logic [7:0] read_mux(input logic [7:0] c);
    unique case (c)
      CMD_RD_DIAG: read_mux = diag_rd;
      CMD_RD_ID:   read_mux = PART_ID;
      CMD_RD_REV:  read_mux = REVISION;
      CMD_RD_CFG:  read_mux = cfg_q;
      CMD_RD_STC:  read_mux = stc_rd;
      default:     read_mux = 8'h00;
    endcase
  endfunction

  // frame sequencing; a frame cut short by chip select is dropped
  always_comb begin
    fr_d = fr_q;
    unique case (fr_q)
      FR_IDLE: if (cs_start) fr_d = FR_CMD;
      FR_CMD:  if (!cs_act) fr_d = FR_IDLE; else if (cmd_bit) fr_d = FR_DATA;
      FR_DATA: if (!cs_act) fr_d = FR_IDLE; else if (last_bit) fr_d = FR_DONE;
      FR_DONE: if (!cs_act) fr_d = FR_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fr_q  <= FR_IDLE;
      cnt_q <= '0;
      rx_q  <= '0;
      cmd_q <= '0;
      tx_q  <= '0;
      miso_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      fr_q <= fr_d;
      oe_q <= cs_act;
      if (cs_start) begin
        cnt_q <= '0;
        tx_q  <= '0;
        miso_q <= 1'b0;
      end else if (sck_rise && (fr_q == FR_CMD || fr_q == FR_DATA)) begin
        rx_q  <= {rx_q[FRAME_BITS-2:0], sync_q[SY_MOSI]};
        cnt_q <= cnt_q + CNT_W'(1);
        if (cmd_bit) begin
          cmd_q <= rx_byte;
          tx_q  <= read_mux(rx_byte);
        end
      end else if (sck_fall && fr_q == FR_DATA) begin
        miso_q <= tx_q[7];
        tx_q   <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // configuration: resets first, then writes, then the held-off overlay
  always_comb begin
    cfg_d = cfg_q;
    if (cmd_clr || sf_mode) cfg_d = CFG_RESET;
    else if (wr_cfg) cfg_d = rx_byte;
    if (held_off) cfg_d = cfg_d | CFG_FORCE;
  end

  always_comb begin
    stc_d = stc_q;
    if (cmd_clr || sf_mode) stc_d = STC_RESET;
    else if (wr_stc) stc_d = rx_byte[7:5];
  end

  // a fault arriving with any clear still wins, so no event is lost
  always_comb begin
    diag_d = diag_q;
    if (cmd_clr || en_edge) diag_d = DIAG_RESET;
    else begin
      if (rd_diag) diag_d = diag_d | DIAG_RD_SET;
      if (wr_stc && !rx_byte[STC_CLR_A]) diag_d = diag_d | DIAG_A_SET;
      if (wr_stc && !rx_byte[STC_CLR_B]) diag_d = diag_d | DIAG_B_SET;
    end
    diag_d = diag_d & fault_event_n;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_q  <= CFG_RESET;
      stc_q  <= STC_RESET;
      diag_q <= DIAG_RESET;
      ov_hold_q <= 1'b0;
    end else begin
      cfg_q  <= cfg_d;
      stc_q  <= stc_d;
      diag_q <= diag_d;
      // an overvoltage seen in the clear cycle still latches
      ov_hold_q <= sync_q[SY_OV] | (ov_hold_q & ~cmd_clr);
    end
  end

  // single stages cannot run at level 4: they fall back to level 3
  wire [1:0] il_sel = {cfg_q[CFG_IL_HI], cfg_q[CFG_IL_LO]};
  wire [1:0] il_eff = (!cfg_q[CFG_MODE] && il_sel == ILIM_LVL4) ? ILIM_LVL3 : il_sel;

  always_ff @(posedge clk) begin
    if (srst) begin
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
      en_q    <= 1'b0;
      mode_q  <= CFG_RESET[CFG_MODE];
      ilim_q  <= ILIM_LVL3;
      edge_q  <= CFG_RESET[CFG_EDGE];
      tst_q   <= STC_RESET[2];
      dir_q   <= STC_RESET[1];
      clr_q   <= 1'b0;
    end else begin
      out_a_q <= cfg_q[CFG_SRC] ? sync_q[SY_PA] : cfg_q[CFG_SA];
      out_b_q <= cfg_q[CFG_SRC] ? sync_q[SY_PB] : cfg_q[CFG_SB];
      en_q    <= ~held_off;
      mode_q  <= cfg_q[CFG_MODE];
      ilim_q  <= il_eff;
      edge_q  <= cfg_q[CFG_EDGE];
      tst_q   <= stc_q[2];
      dir_q   <= stc_q[1];
      clr_q   <= cmd_clr;
    end
  end

  assign miso                  = miso_q;
  assign miso_oe               = oe_q;
  assign bridge_output_a       = out_a_q;
  assign bridge_output_b       = out_b_q;
  assign stage_enable          = en_q;
  assign hbridge_mode          = mode_q;
  assign ilim_level            = ilim_q;
  assign edge_rate_select      = edge_q;
  assign threshold_test_off    = tst_q;
  assign threshold_shift_dir   = dir_q;
  assign commanded_logic_clear = clr_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_power_up_cfg: assert property (@(posedge clk) disable iff (1'b0)
    srst |=> (cfg_q == CFG_RESET) && (stc_q == STC_RESET) && (diag_q == DIAG_RESET))
    else $error("power-up contents wrong");
  a_cmd_reset: assert property (cmd_clr && !sf_mode |=> cfg_q == CFG_RESET && stc_q == STC_RESET)
    else $error("commanded reset did not restore registers");
  a_held_force: assert property (held_off |=> (cfg_q & CFG_FORCE) == CFG_FORCE)
    else $error("held-off bits not forced");
  a_enable_edge: assert property (en_edge && (&fault_event_n) |=> diag_q == DIAG_RESET)
    else $error("enable edge did not clear diagnosis");
  a_read_rearm: assert property (rd_diag && !en_edge && !cmd_clr
    |=> diag_q[6:4] == $past(fault_event_n[6:4]) && diag_q[3:0] == $past(diag_q[3:0] & fault_event_n[3:0]))
    else $error("diagnosis read cleared the wrong bits");
  a_clear_a: assert property (wr_stc && !rx_byte[STC_CLR_A] && (&fault_event_n[1:0]) |=> diag_q[1:0] == 2'b11)
    else $error("clear of output a failed");
  a_clear_b: assert property (wr_stc && !rx_byte[STC_CLR_B] && (&fault_event_n[3:2]) |=> diag_q[3:2] == 2'b11)
    else $error("clear of output b failed");
  a_flag_mode: assert property (sf_mode |=> cfg_q == CFG_RESET && stc_q == STC_RESET)
    else $error("flag-only mode did not reset");
  a_serial_drive: assert property (!cfg_q[CFG_SRC] ##1 !$changed(cfg_q) |-> out_a_q == cfg_q[CFG_SA])
    else $error("serial drive bit not followed");
  a_level_cap: assert property (!cfg_q[CFG_MODE] |=> ilim_q != ILIM_LVL4)
    else $error("single stages above level 3");
  a_event_low: assert property (!fault_event_n[6] |=> !diag_q[6])
    else $error("overheat event lost");

  c_write_cfg: cover property (wr_cfg ##1 cfg_q[CFG_SRC] == 1'b0);
  c_read_diag: cover property (rd_diag ##[1:40] cs_act == 1'b0);
  c_enable_edge: cover property (en_edge);
  c_cmd_reset: cover property (cmd_clr);
endmodule // hbc_regs
`default_nettype wire

/* hbc_spi_host.sv */
/*
  behavioural serial host for the h-bridge configuration block: sends
  16-bit frames, command byte then data byte, msb first, mode 0.
  assumes clk is the block clock; sclk half period is 8 clk (80 ns).
*/
`default_nettype none
module hbc_spi_host (
  input  wire logic clk,
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  task automatic half();
    repeat (8) @(posedge clk);
    #1;
  endtask

  // sclk stands low outside frames; data captured on the rising edge
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, dat};
    rd = 8'h00;
    @(posedge clk);
    #1;
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi = sh[i];
      half();
      sclk = 1'b1;
      if (i < 8) rd = {rd[6:0], miso};
      half();
      sclk = 1'b0;
    end
    // released data line must not look like a held bit
    mosi = ~mosi;
    cs_n = 1'b1;
    repeat (8) @(posedge clk);
    #1;
  endtask
endmodule // hbc_spi_host
`default_nettype wire

/* hbc_tb.sv */
/*
  self-checking bench for hbc_regs: frames from hbc_spi_host, pin stimulus,
  checks of register read-back and registered outputs.
  assumes hbc_pkg and hbc_spi_host are compiled first.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import hbc_pkg::*;
  localparam logic [7:0] ID_VAL  = 8'h3c; // arbitrary value
  localparam logic [7:0] REV_VAL = 8'h21; // arbitrary value
  logic       clk, srst, sclk, cs_n, mosi, miso, miso_oe, pa, pb, en_n, dis, sfm, uv, ov;
  logic       out_a, out_b, stage_enable, hbridge_mode, edge_rate_select;
  logic       threshold_test_off, threshold_shift_dir, commanded_logic_clear;
  logic [1:0] ilim_level;
  logic [6:0] fev;
  logic [7:0] v;
  logic [8:0] outs;
  int         err_count = 0;
  int         n_tests = 0;
  int         pulses = 0;
  int         oe_cycles = 0;

  assign outs = {out_a, out_b, stage_enable, hbridge_mode, ilim_level, edge_rate_select,
                 threshold_test_off, threshold_shift_dir};

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) if (commanded_logic_clear === 1'b1) pulses <= pulses + 1;
  always @(posedge clk) if (miso_oe === 1'b1) oe_cycles <= oe_cycles + 1;

  hbc_spi_host u_host (.clk, .sclk, .cs_n, .mosi, .miso);

  hbc_regs #(.PART_ID(ID_VAL), .REVISION(REV_VAL)) DUT (
    .clk, .srst, .sclk, .cs_n, .mosi, .miso, .miso_oe,
    .parallel_drive_a(pa), .parallel_drive_b(pb), .bridge_enable_pin_n(en_n),
    .bridge_disable_pin(dis), .flag_only_mode(sfm), .supply_under(uv),
    .supply_over(ov), .fault_event_n(fev), .bridge_output_a(out_a),
    .bridge_output_b(out_b), .stage_enable, .hbridge_mode, .ilim_level,
    .edge_rate_select, .threshold_test_off, .threshold_shift_dir, .commanded_logic_clear
  );

  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [8:0] exp);
    cmp(outs, exp);
  endtask
  task automatic rdc(input logic [7:0] c, input logic [7:0] e);
    u_host.xfer(c, 8'h00, v);
    cmp({1'b0, v}, {1'b0, e});
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    u_host.xfer(c, d, x);
  endtask
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask
  // every fault event low for one clk
  task automatic ev_pulse();
    @(posedge clk);
    #1;
    fev = 7'h00;
    @(posedge clk);
    #1;
    fev = 7'h7f;
  endtask

  task automatic t_power_up();
    int o0;
    chk_out(9'h073);
    o0 = oe_cycles;
    rdc(CMD_RD_CFG, 8'hfa);
    cmp(9'(oe_cycles - o0), 9'h100); // output enable spans 16 bit times of one frame
    rdc(CMD_RD_STC, 8'hdf);
    rdc(CMD_RD_DIAG, 8'hff);
    $display("test power_up done");
  endtask

  task automatic t_ilim();
    for (int i = 0; i < 4; i++) begin
      wr(CMD_WR_CFG, 8'ha3 | (8'(i) << 2));
      chk_out(9'h167 | (9'(i) << 3));
    end
    wr(CMD_WR_CFG, 8'h1e);
    chk_out(9'h0d3);
    rdc(CMD_RD_CFG, 8'h1e);
    $display("test ilim done");
  endtask

  task automatic t_pins();
    wr(CMD_WR_CFG, 8'hca);
    pa = 1'b1;
    settle();
    chk_out(9'h173);
    pa = 1'b0;
    pb = 1'b1;
    settle();
    chk_out(9'h0f3);
    $display("test pins done");
  endtask

  task automatic t_cmd_reset();
    int p0;
    wr(CMD_WR_STC, 8'h38);
    chk_out(9'h0f0);
    rdc(CMD_RD_STC, 8'h3f);
    ev_pulse();
    p0 = pulses;
    wr(CMD_WR_CFG, 8'h0c);
    cmp(9'(pulses - p0), 9'h001);
    rdc(CMD_RD_DIAG, 8'hff);
    rdc(CMD_RD_CFG, 8'hfa);
    rdc(CMD_RD_STC, 8'hdf);
    chk_out(9'h0f3);
    $display("test cmd_reset done");
  endtask

  task automatic t_supply();
    uv = 1'b1;
    settle();
    rdc(CMD_RD_STC, 8'hdd);
    uv = 1'b0;
    wr(CMD_WR_STC, 8'hf8);
    ov = 1'b1;
    settle();
    rdc(CMD_RD_STC, 8'hfe);
    ov = 1'b0;
    settle();
    rdc(CMD_RD_STC, 8'hfe);
    wr(CMD_WR_STC, 8'hd8);
    rdc(CMD_RD_STC, 8'hdf);
    $display("test supply done");
  endtask

  task automatic t_diag();
    ev_pulse();
    rdc(CMD_RD_DIAG, 8'h80);
    rdc(CMD_RD_DIAG, 8'hf0);
    wr(CMD_WR_STC, 8'hd0);
    rdc(CMD_RD_DIAG, 8'hf3);
    wr(CMD_WR_STC, 8'hc8);
    rdc(CMD_RD_DIAG, 8'hff);
    rdc(CMD_RD_STC, 8'hdf);
    $display("test diag done");
  endtask

  task automatic t_held();
    wr(CMD_WR_CFG, 8'h8e);
    ev_pulse();
    en_n = 1'b0;
    settle();
    chk_out(9'h0bb);
    rdc(CMD_RD_CFG, 8'hfe);
    rdc(CMD_RD_DIAG, 8'h7f);
    rdc(CMD_RD_STC, 8'hdb);
    ev_pulse();
    en_n = 1'b1;
    settle();
    rdc(CMD_RD_DIAG, 8'hff);
    rdc(CMD_RD_CFG, 8'hfe);
    dis = 1'b1;
    settle();
    chk_out(9'h0bb);
    dis = 1'b0;
    settle();
    $display("test held done");
  endtask

  task automatic t_flag();
    wr(CMD_WR_CFG, 8'h8e);
    wr(CMD_WR_STC, 8'h58);
    chk_out(9'h079);
    sfm = 1'b1;
    settle();
    sfm = 1'b0;
    rdc(CMD_RD_CFG, 8'hfa);
    rdc(CMD_RD_STC, 8'hdf);
    rdc(CMD_RD_ID, ID_VAL);
    rdc(CMD_RD_REV, REV_VAL);
    $display("test flag done");
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    srst = 1'b1;
    {pa, pb, dis, sfm, uv, ov} = 6'h00;
    en_n = 1'b1;
    fev = 7'h7f;
    repeat (4) @(posedge clk);
    #1;
    srst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    t_power_up();
    t_ilim();
    t_pins();
    t_cmd_reset();
    t_supply();
    t_diag();
    t_held();
    t_flag();
    wrap_up();
  end

  // about 41 frames of 2.7 us each are expected
  initial begin
    #500000;
    err_count++;
    $display("ERROR %0t watchdog expired", $time);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
